// ===== dvm_pkg.sv
// Package with decode constants, flag positions and carrier types for the vector multiply datapath.
package dvm_pkg;
    localparam logic [5:0]  MAJOR_OPCODE_CLASS      = 6'h1F;
    localparam logic [5:0]  FUNC_CLASS_VECTOR_ARITH = 6'h10;
    localparam logic [5:0]  FUNC_CLASS_DOT_PRODUCT  = 6'h30;
    localparam logic [4:0]  SUB_UBYTE_UHALF_RIGHT   = 5'h07;
    localparam logic [4:0]  SUB_Q15_PAIR_ROUND      = 5'h1F;
    localparam logic [4:0]  SUB_SUB_ACCUMULATE      = 5'h06;
    localparam int          OUFLAG_REG_BIT          = 21;
    localparam int          OUFLAG_ACC_BASE         = 16;
    localparam logic [31:0] Q15_ROUND_CONST         = 32'h0000_8000;
    localparam logic [31:0] Q31_MAX                 = 32'h7FFF_FFFF;
    localparam logic [15:0] Q15_MIN                 = 16'h8000;
    localparam logic [15:0] UHALF_MAX               = 16'hFFFF;
    localparam logic [63:0] ACC_RESET               = 64'h0;
    localparam int          ACC_COUNT               = 4;

    typedef enum logic [3:0] {
        DVM_OP_NONE  = 4'b0001,
        DVM_OP_UBYTE = 4'b0010,
        DVM_OP_QRND  = 4'b0100,
        DVM_OP_MSAC  = 4'b1000
    } dvm_op_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [31:0] src_reg_a;
        logic [31:0] src_reg_b;
        logic        exc_reserved;
        logic        exc_dsp_disabled;
    } dvm_issue_type;

    typedef struct packed {
        logic        reg_we;
        logic [4:0]  reg_addr;
        logic [31:0] reg_data;
        logic        acc_we;
        logic [1:0]  acc_idx;
        logic [63:0] acc_data;
        logic [31:0] ouflag_set;
    } dvm_result_type;
endpackage

// ===== dvm_q15_lane.sv
// One signed Q15 lane multiplier with the doubled product and the corner clamp.
`timescale 1ns/1ps
module dvm_q15_lane (
    input  wire logic [15:0] lane_a_in,
    input  wire logic [15:0] lane_b_in,
    output logic      [31:0] q31_out,
    output logic             sat_out
);
    import dvm_pkg::*;
    logic signed [31:0] prod;

    always_comb begin
        prod    = $signed(lane_a_in) * $signed(lane_b_in);
        sat_out = (lane_a_in == Q15_MIN) && (lane_b_in == Q15_MIN);
        q31_out = sat_out ? Q31_MAX : {prod[30:0], 1'b0};
    end
endmodule

// ===== dvm_datapath.sv
// Execution datapath for the byte-halfword, rounding Q15 and multiply-subtract-accumulate operations.
`timescale 1ns/1ps
module dvm_datapath #(
    parameter int ACC_NUM = 4
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_b_in,
    input  wire dvm_pkg::dvm_issue_type  issue_in,
    output logic                         decode_hit_out,
    output dvm_pkg::dvm_result_type      result_out,
    output logic [31:0]                  acc_high_word_out,
    output logic [31:0]                  acc_low_word_out
);
    import dvm_pkg::*;

    dvm_op_type         op;
    logic [5:0]         major;
    logic [4:0]         sub_op;
    logic [5:0]         func;
    logic [1:0]         accumulator_index;
    logic               suppress;
    logic [63:0]        acc [ACC_NUM];
    logic [31:0]        hi_q31;
    logic [31:0]        lo_q31;
    logic               hi_sat;
    logic               lo_sat;
    logic [23:0]        uprod_hi;
    logic [23:0]        uprod_lo;
    logic               usat_hi;
    logic               usat_lo;
    logic [15:0]        ulane_hi;
    logic [15:0]        ulane_lo;
    logic [31:0]        rnd_hi;
    logic [31:0]        rnd_lo;
    logic [63:0]        diff_ext;
    logic [63:0]        next_acc;
    dvm_result_type     next_result;

    assign major             = issue_in.instr[31:26];
    assign sub_op            = issue_in.instr[10:6];
    assign func              = issue_in.instr[5:0];
    assign accumulator_index = issue_in.instr[12:11];
    assign suppress          = issue_in.exc_reserved || issue_in.exc_dsp_disabled;

    always_comb begin
        op = DVM_OP_NONE;
        if (!issue_in.valid || major != MAJOR_OPCODE_CLASS) begin
            op = DVM_OP_NONE;
        end else if (func == FUNC_CLASS_VECTOR_ARITH && sub_op == SUB_UBYTE_UHALF_RIGHT) begin
            op = DVM_OP_UBYTE;
        end else if (func == FUNC_CLASS_VECTOR_ARITH && sub_op == SUB_Q15_PAIR_ROUND) begin
            op = DVM_OP_QRND;
        end else if (func == FUNC_CLASS_DOT_PRODUCT && sub_op == SUB_SUB_ACCUMULATE
                     && issue_in.instr[15:13] == 3'b000) begin
            op = DVM_OP_MSAC;
        end
    end

    assign decode_hit_out = (op != DVM_OP_NONE);

    dvm_q15_lane u_lane_hi (
        .lane_a_in (issue_in.src_reg_a[31:16]),
        .lane_b_in (issue_in.src_reg_b[31:16]),
        .q31_out   (hi_q31),
        .sat_out   (hi_sat)
    );

    dvm_q15_lane u_lane_lo (
        .lane_a_in (issue_in.src_reg_a[15:0]),
        .lane_b_in (issue_in.src_reg_b[15:0]),
        .q31_out   (lo_q31),
        .sat_out   (lo_sat)
    );

    always_comb begin
        uprod_hi = issue_in.src_reg_a[15:8] * issue_in.src_reg_b[31:16];
        uprod_lo = issue_in.src_reg_a[7:0] * issue_in.src_reg_b[15:0];
        usat_hi  = |uprod_hi[23:16];
        usat_lo  = |uprod_lo[23:16];
        ulane_hi = usat_hi ? UHALF_MAX : uprod_hi[15:0];
        ulane_lo = usat_lo ? UHALF_MAX : uprod_lo[15:0];
        rnd_hi   = hi_q31 + Q15_ROUND_CONST;
        rnd_lo   = lo_q31 + Q15_ROUND_CONST;
        if (hi_sat) begin
            rnd_hi = Q31_MAX;
        end
        if (lo_sat) begin
            rnd_lo = Q31_MAX;
        end
        diff_ext = {{32{1'b0}}, 32'h0};
        diff_ext = $signed({{32{hi_q31[31]}}, hi_q31}) - $signed({{32{lo_q31[31]}}, lo_q31});
        next_acc = acc[accumulator_index] + diff_ext;
    end

    always_comb begin
        next_result          = '0;
        next_result.reg_addr = issue_in.instr[15:11];
        next_result.acc_idx  = accumulator_index;
        next_result.acc_data = next_acc;
        case (op)
            DVM_OP_UBYTE: begin
                next_result.reg_we   = !suppress;
                next_result.reg_data = {ulane_hi, ulane_lo};
                next_result.ouflag_set[OUFLAG_REG_BIT] = !suppress && (usat_hi || usat_lo);
            end
            DVM_OP_QRND: begin
                next_result.reg_we   = !suppress;
                next_result.reg_data = {rnd_hi[31:16], rnd_lo[31:16]};
                next_result.ouflag_set[OUFLAG_REG_BIT] = !suppress && (hi_sat || lo_sat);
            end
            DVM_OP_MSAC: begin
                next_result.acc_we = !suppress;
                next_result.ouflag_set[OUFLAG_ACC_BASE + int'(accumulator_index)] =
                    !suppress && (hi_sat || lo_sat);
            end
            default: begin
                next_result = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            result_out <= '0;
        end else begin
            result_out <= next_result;
        end
    end

    // Register-targeting operations leave every accumulator alone, so index zero keeps its value too.
    // Accumulator update only.
    generate
        for (genvar i = 0; i < ACC_NUM; i++) begin : g_acc
            always_ff @(posedge clk_in) begin
                if (!rst_b_in) begin
                    acc[i] <= ACC_RESET;
                end else if (next_result.acc_we && next_result.acc_idx == 2'(i)) begin
                    acc[i] <= next_acc;
                end
            end
        end
    endgenerate

    assign acc_high_word_out = acc[0][63:32];
    assign acc_low_word_out  = acc[0][31:0];
endmodule

// ===== dvm_pipe_model.sv
// Pipeline-side model that issues decoded instructions to the datapath.
`timescale 1ns/1ps
module dvm_pipe_model (
    input  wire logic              clk_in,
    output dvm_pkg::dvm_issue_type issue_out
);
    import dvm_pkg::*;
    initial issue_out = '0;
    task automatic send(input logic [31:0] ins, a, b, input logic [1:0] exc);
        @(negedge clk_in);
        issue_out <= '{1'b1, ins, a, b, exc[1], exc[0]};
    endtask
    // A bubble inverts the stale instruction and operand fields and clears the exception bits so nothing downstream can lean on them.
    task automatic idle();
        @(negedge clk_in);
        issue_out <= '{1'b0, ~issue_out.instr, ~issue_out.src_reg_a, ~issue_out.src_reg_b, 1'b0, 1'b0};
    endtask
endmodule

// ===== dvm_monitor.sv
// Port checker for the vector multiply datapath.
`timescale 1ns/1ps
module dvm_monitor (
    input wire logic                    clk_in,
    input wire logic                    rst_b_in,
    input wire dvm_pkg::dvm_issue_type  issue_in,
    input wire logic                    decode_hit_out,
    input wire dvm_pkg::dvm_result_type result_out,
    input wire logic [31:0]             acc_high_word_out,
    input wire logic [31:0]             acc_low_word_out
);
    import dvm_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    wire dvm_issue_type  i = issue_in;
    wire dvm_result_type r = result_out;
    wire logic           x = i.exc_reserved | i.exc_dsp_disabled;
    sequence s_clamp;
        i.valid && !x && i.instr[31:26] == 6'h1F && i.instr[10:0] == 11'h7D0
        && i.src_reg_a[31:16] == 16'h8000 && i.src_reg_b[31:16] == 16'h8000;
    endsequence
    a_round_clamp: assert property (s_clamp |=> r.reg_data[31:16] == 16'h7FFF && r.ouflag_set[21])
        else $error("clamp lane wrong");
    a_idle_zero: assert property (!i.valid |=> r == '0)
        else $error("write without issue");
    a_exc_quiet: assert property (i.valid && x |=> !r.reg_we && !r.acc_we && r.ouflag_set == '0)
        else $error("suppressed op wrote");
    a_dest_addr: assert property (r.reg_we |-> r.reg_addr == $past(i.instr[15:11]))
        else $error("wrong destination");
    a_flag_range: assert property ((r.ouflag_set & 32'hFFD0_FFFF) == '0)
        else $error("flag outside field");
    a_acc_flag: assert property (r.acc_we && |r.ouflag_set |-> r.ouflag_set == 32'h1 << (16 + r.acc_idx))
        else $error("accumulate flag wrong");
    a_acc0_copy: assert property (r.acc_we && r.acc_idx == 2'h0 |-> {acc_high_word_out, acc_low_word_out} == r.acc_data)
        else $error("acc0 not updated");
    a_acc0_keep: assert property (decode_hit_out && i.instr[5:0] == 6'h10 |=> $stable({acc_high_word_out, acc_low_word_out}))
        else $error("acc0 disturbed");
    a_bad_field: assert property (i.valid && i.instr[31:26] == 6'h1F && i.instr[10:0] == 11'h1B0
        && |i.instr[15:13] |-> !decode_hit_out)
        else $error("bad field decoded");
endmodule
bind dvm_datapath dvm_monitor dvm_monitor_inst (.clk_in, .rst_b_in, .issue_in, .decode_hit_out,
    .result_out, .acc_high_word_out, .acc_low_word_out);

// ===== dvm_datapath_test.sv
// Self-checking bench for the vector multiply datapath.
`timescale 1ns/1ps
module dvm_datapath_test;
    import dvm_pkg::*;
    logic           clk_in = 1'b0;
    logic           rst_b_in = 1'b0;
    dvm_issue_type  iss;
    dvm_result_type res;
    logic           hit;
    logic [31:0]    hi_w;
    logic [31:0]    lo_w;
    int             error_cnt = 0;
    int             check_count = 0;
    int             cycles = 0;
    always #5 clk_in = ~clk_in;
    dvm_pipe_model dvm_pipe_model_inst (.clk_in, .issue_out(iss));
    dvm_datapath dvm_datapath_inst (.clk_in, .rst_b_in, .issue_in(iss), .decode_hit_out(hit),
        .result_out(res), .acc_high_word_out(hi_w), .acc_low_word_out(lo_w));
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // Sources sit in fields 2 and 1; f holds the sub-operation and function fields.
    task automatic run(input logic [10:0] f, input logic [4:0] rd, input logic [31:0] a, b,
        input logic [1:0] exc, we, input logic [63:0] d, input logic [31:0] fl);
        dvm_pipe_model_inst.send({6'h1F, 10'h041, rd, f}, a, b, exc);
        #1;
        check({63'h0, hit}, {63'h0, (we != 2'b00) || (exc != 2'b00)});
        @(posedge clk_in);
        #1;
        check({res.reg_we, res.acc_we, res.ouflag_set}, {we, fl});
        if (we != 2'b00)
            check(res.acc_we ? res.acc_data : {32'h0, res.reg_data}, d);
    endtask
    task automatic t_ubyte();
        run(11'h1D0, 5'h05, 32'h0000_0302, 32'h1000_7FFF, 2'b00, 2'b10, 64'h3000_FFFE, 32'h0);
        run(11'h1D0, 5'h05, 32'h0000_FF01, 32'h0102_FFFF, 2'b00, 2'b10, 64'hFFFF_FFFF, 32'h0020_0000);
        $display("ubyte test ended");
    endtask
    task automatic t_qrnd();
        run(11'h7D0, 5'h06, 32'h8000_4000, 32'h8000_4000, 2'b00, 2'b10, 64'h7FFF_2000, 32'h0020_0000);
        run(11'h7D0, 5'h06, 32'h0001_FFFF, 32'h4000_0001, 2'b00, 2'b10, 64'h0001_0000, 32'h0);
        dvm_pipe_model_inst.idle();
        $display("round test ended");
    endtask
    task automatic t_msac();
        run(11'h1B0, 5'h02, 32'h8000_0002, 32'h8000_0003, 2'b00, 2'b01, 64'h7FFF_FFF3, 32'h0004_0000);
        run(11'h1B0, 5'h02, 32'h0000_8000, 32'h0000_7FFF, 2'b00, 2'b01, 64'hFFFE_FFF3, 32'h0);
        run(11'h1B0, 5'h00, 32'h1, 32'h1, 2'b00, 2'b01, 64'hFFFF_FFFF_FFFF_FFFE, 32'h0);
        check({hi_w, lo_w}, 64'hFFFF_FFFF_FFFF_FFFE);
        run(11'h1D0, 5'h05, 32'h1, 32'h1, 2'b00, 2'b10, 64'h1, 32'h0);
        check({hi_w, lo_w}, 64'hFFFF_FFFF_FFFF_FFFE);
        $display("accumulate test ended");
    endtask
    task automatic t_refuse();
        run(11'h1D0, 5'h05, 32'h0000_FF01, 32'h0102_FFFF, 2'b10, 2'b00, 64'h0, 32'h0);
        run(11'h1B0, 5'h00, 32'h8000_0001, 32'h8000_0001, 2'b01, 2'b00, 64'h0, 32'h0);
        check({hi_w, lo_w}, 64'hFFFF_FFFF_FFFF_FFFE);
        run(11'h1B0, 5'h08, 32'h1, 32'h1, 2'b00, 2'b00, 64'h0, 32'h0);
        dvm_pipe_model_inst.idle();
        $display("refusal test ended");
    endtask
    initial begin
        repeat (12) @(negedge clk_in);
        rst_b_in = 1'b1;
        t_ubyte();
        t_qrnd();
        t_msac();
        t_refuse();
        conclude();
    end
endmodule
